// file: src/cmm_pkg.sv
// Shared constants and types for the chip mode and memory map block
package cmm_pkg;

	// Chip modes held in the mode register
	typedef enum logic [1:0] {
		CMM_NORMAL,
		CMM_BOOT,
		CMM_NORMAL_AUX,
		CMM_BOOT_AUX
	} cmm_mode_t;

	// Unlock sequencer states
	typedef enum logic [1:0] {
		CMM_UL_IDLE,
		CMM_UL_ARMED,
		CMM_UL_KEY1
	} cmm_unlock_t;

	// Address widths of the three CPU spaces
	localparam int          ADDR_W         = 16;
	localparam int          IADDR_W        = 8;

	// Program ROM/RAM region: 8 Kbyte from 0000h
	localparam logic [15:0] PROG_BASE      = 16'h0000;
	localparam logic [16:0] PROG_SIZE      = 17'h02000;
	// Boot and self-test ROM: 4 Kbyte from 0000h
	localparam logic [15:0] BOOT_BASE      = 16'h0000;
	localparam logic [16:0] BOOT_SIZE      = 17'h01000;
	// Auxiliary data RAM: 256 bytes from FF00h
	localparam logic [15:0] AUX_BASE       = 16'hFF00;
	localparam logic [16:0] AUX_SIZE       = 17'h00100;

	// Internal data memory 256 bytes, special function area 128 bytes
	localparam logic [7:0]  IDATA_BASE     = 8'h00;
	localparam logic [8:0]  IDATA_SIZE     = 9'h100;
	localparam logic [7:0]  SFR_BASE       = 8'h80;
	localparam logic [8:0]  SFR_SIZE       = 9'h080;

	// Unlock sequence: two key bytes in order after the control write
	localparam logic [7:0]  UNLOCK_KEY1    = 8'h3C;
	localparam logic [7:0]  UNLOCK_KEY2    = 8'hC3;
	// Time allowed for the whole unlock sequence, in ns and cycles
	localparam int          CLK_PERIOD_NS  = 40;
	localparam int          UNLOCK_TIME_NS = 640;
	localparam int          UNLOCK_CYC     = UNLOCK_TIME_NS / CLK_PERIOD_NS;

	// Reset value of the mode register while reset is held
	localparam cmm_mode_t   MODE_RESET     = CMM_NORMAL;

endpackage

// file: src/cmm_region.sv
// Address window decoder: hit flag and offset inside one region
`timescale 1ns/1ps
module cmm_region
#(
	parameter int                 W     = 16,
	parameter logic [W-1:0]       BASE  = '0,
	parameter logic [W:0]         SIZE  = '0
)
(
	input  wire logic [W-1:0]     addr,
	output logic                  hit,
	output logic [W-1:0]          offset
);

	logic [W:0] diff;

	// Borrow out means below base; wrap-free compare against size
	assign diff   = {1'b0, addr} - {1'b0, BASE};
	assign hit    = !diff[W] && (diff < SIZE);
	assign offset = diff[W-1:0];

endmodule

// file: src/cmm_chip_mode.sv
// Chip mode selection and memory map decode for the on-chip CPU
//
// Summary of operation
// [RL1] Reset release: pin high normal, low bootstrap
// [RL2] Bits 0,0 then unlock selects normal mode
// [RL3] Bits 0,1 then unlock: normal auxiliary mode
// [RL4] Bits 1,1 then unlock: bootstrap auxiliary mode
// [RL5] Bits 1,0 then unlock selects bootstrap mode
// [RL6] Software selection ignores the boot pin
// [RL7] Hardware reset overrides any software mode change
// [RL8] Normal: code program memory, data auxiliary RAM
// [RL9] Bootstrap: code fetches from boot ROM
// [RL10] Bootstrap data: auxiliary RAM plus program memory
// [RL11] Normal auxiliary: code auxiliary RAM, data program
// [RL12] Bootstrap auxiliary: code boot plus auxiliary RAM
// [RL13] Provide 4K boot ROM, 8K program memory
// [RL14] Internal data and auxiliary RAM separate spaces
// [RL15] 128 byte special function area separate
// [RL16] Mode register loads only at reset, unlock
`timescale 1ns/1ps
module cmm_chip_mode
	import cmm_pkg::*;
#(
	parameter logic [16:0]        PROG_LIMIT   = cmm_pkg::PROG_SIZE,
	parameter logic [16:0]        BOOT_LIMIT   = cmm_pkg::BOOT_SIZE,
	parameter logic [16:0]        AUX_LIMIT    = cmm_pkg::AUX_SIZE,
	parameter logic [7:0]         KEY_FIRST    = cmm_pkg::UNLOCK_KEY1,
	parameter logic [7:0]         KEY_SECOND   = cmm_pkg::UNLOCK_KEY2
)
(
	input  wire logic                  core_clk,
	input  wire logic                  rst_b,
	input  wire logic                  boot_select_pin,
	input  wire logic                  ctl_wr,
	input  wire logic                  boot_loader_enable_bit,
	input  wire logic                  code_swap_bit,
	input  wire logic                  unlock_wr,
	input  wire logic [7:0]            unlock_data,
	input  wire logic                  fetch_req,
	input  wire logic [15:0]           fetch_addr,
	input  wire logic                  xdata_req,
	input  wire logic [15:0]           xdata_addr,
	input  wire logic                  idata_req,
	input  wire logic                  idata_direct,
	input  wire logic [7:0]            idata_addr,
	output cmm_pkg::cmm_mode_t         chip_mode,
	output logic                       mode_loaded,
	output logic                       unlock_armed,
	output logic                       unlock_abort,
	output logic                       fetch_prog_sel,
	output logic                       fetch_boot_sel,
	output logic                       fetch_aux_sel,
	output logic                       fetch_miss,
	output logic [15:0]                fetch_offset,
	output logic                       xdata_prog_sel,
	output logic                       xdata_aux_sel,
	output logic                       xdata_miss,
	output logic [15:0]                xdata_offset,
	output logic                       idata_ram_sel,
	output logic                       sfr_sel,
	output logic [7:0]                 idata_offset
);

	import cmm_pkg::*;

	localparam logic [7:0] TIMER_LOAD = 8'(UNLOCK_CYC);

	logic                boot_pin_meta;
	logic                boot_pin_sync;
	logic                strap_pending;
	cmm_mode_t           next_mode;
	logic                load_mode;
	logic                pend_bsl_en;
	logic                pend_swap;
	cmm_unlock_t         ul_state;
	cmm_unlock_t         next_ul_state;
	logic [7:0]          ul_timer;
	logic                ul_expired;
	logic                key1_ok;
	logic                key2_ok;
	logic                sw_unlock_done;
	logic                abort_now;
	cmm_mode_t           sw_mode;
	cmm_mode_t           strap_mode;

	logic                f_prog_hit;
	logic                f_boot_hit;
	logic                f_aux_hit;
	logic [15:0]         f_prog_off;
	logic [15:0]         f_boot_off;
	logic [15:0]         f_aux_off;
	logic                x_prog_hit;
	logic                x_aux_hit;
	logic [15:0]         x_prog_off;
	logic [15:0]         x_aux_off;
	logic                i_ram_hit;
	logic                i_sfr_hit;
	logic [7:0]          i_ram_off;
	logic [7:0]          i_sfr_off;

	logic                map_code_prog;
	logic                map_code_boot;
	logic                map_code_aux;
	logic                map_data_prog;
	logic                map_data_aux;
	logic                next_f_prog;
	logic                next_f_boot;
	logic                next_f_aux;
	logic [15:0]         next_f_off;
	logic                next_x_prog;
	logic                next_x_aux;
	logic [15:0]         next_x_off;
	logic                next_i_ram;
	logic                next_i_sfr;
	logic [7:0]          next_i_off;

	// Boot pin crosses in from outside; left unreset so the synced
	// level is already valid on the first edge after reset release
	always_ff @(posedge core_clk)
	begin
		boot_pin_meta <= boot_select_pin;
		boot_pin_sync <= boot_pin_meta;
	end

	// Strap sample point: first edge after reset goes high
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
			strap_pending <= 1'b1;
		else
			strap_pending <= 1'b0;
	end

	assign strap_mode = boot_pin_sync ? CMM_NORMAL : CMM_BOOT; // RL1

	// Control bit pair to mode; the pin is not looked at here
	assign sw_mode = !pend_bsl_en && !pend_swap ? CMM_NORMAL // RL2 RL6
		: !pend_bsl_en && pend_swap ? CMM_NORMAL_AUX // RL3
		: pend_bsl_en && pend_swap ? CMM_BOOT_AUX // RL4
		: CMM_BOOT; // RL5

	// Unlock key checks
	assign key1_ok        = unlock_wr && (unlock_data == KEY_FIRST);
	assign key2_ok        = unlock_wr && (unlock_data == KEY_SECOND);
	assign ul_expired     = (ul_timer == 8'h00);
	assign sw_unlock_done = (ul_state == CMM_UL_KEY1) && key2_ok
		&& !ctl_wr && !ul_expired;

	// Unlock sequencer: control write arms, two keys in order load
	always_comb
	begin
		next_ul_state = ul_state;
		abort_now     = 1'b0;
		case (ul_state)
			CMM_UL_IDLE:
			begin
				if (ctl_wr)
					next_ul_state = CMM_UL_ARMED;
			end
			CMM_UL_ARMED:
			begin
				if (ctl_wr)
					next_ul_state = CMM_UL_ARMED;
				else if (ul_expired || (unlock_wr && !key1_ok))
				begin
					next_ul_state = CMM_UL_IDLE;
					abort_now     = 1'b1;
				end
				else if (key1_ok)
					next_ul_state = CMM_UL_KEY1;
			end
			CMM_UL_KEY1:
			begin
				if (ctl_wr)
					next_ul_state = CMM_UL_ARMED;
				else if (sw_unlock_done)
					next_ul_state = CMM_UL_IDLE;
				else if (ul_expired || unlock_wr)
				begin
					next_ul_state = CMM_UL_IDLE;
					abort_now     = 1'b1;
				end
			end
			default:
				next_ul_state = CMM_UL_IDLE;
		endcase
	end

	// Sequencer state, timer and the pending control bits
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			ul_state    <= CMM_UL_IDLE;
			ul_timer    <= 8'h00;
			pend_bsl_en <= 1'b0;
			pend_swap   <= 1'b0;
		end
		else
		begin
			ul_state <= next_ul_state;
			if (ctl_wr)
			begin
				ul_timer    <= TIMER_LOAD;
				pend_bsl_en <= boot_loader_enable_bit;
				pend_swap   <= code_swap_bit;
			end
			else if (!ul_expired)
				ul_timer <= ul_timer - 8'h01;
		end
	end

	// Strap load wins over a software load in the same cycle
	assign load_mode = strap_pending || sw_unlock_done; // RL16
	assign next_mode = strap_pending ? strap_mode : sw_mode; // RL7

	// Mode register; control writes alone never touch it
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			chip_mode    <= MODE_RESET; // RL7
			mode_loaded  <= 1'b0;
			unlock_armed <= 1'b0;
			unlock_abort <= 1'b0;
		end
		else
		begin
			if (load_mode)
				chip_mode <= next_mode; // RL16
			mode_loaded  <= load_mode;
			unlock_armed <= (next_ul_state != CMM_UL_IDLE);
			unlock_abort <= abort_now;
		end
	end

	// Region decoders for code and external data addresses
	cmm_region #(.W(ADDR_W), .BASE(PROG_BASE), .SIZE(PROG_LIMIT))
		u_f_prog (.addr(fetch_addr), .hit(f_prog_hit), .offset(f_prog_off));
	cmm_region #(.W(ADDR_W), .BASE(BOOT_BASE), .SIZE(BOOT_LIMIT))
		u_f_boot (.addr(fetch_addr), .hit(f_boot_hit), .offset(f_boot_off));
	cmm_region #(.W(ADDR_W), .BASE(AUX_BASE), .SIZE(AUX_LIMIT))
		u_f_aux (.addr(fetch_addr), .hit(f_aux_hit), .offset(f_aux_off));
	cmm_region #(.W(ADDR_W), .BASE(PROG_BASE), .SIZE(PROG_LIMIT))
		u_x_prog (.addr(xdata_addr), .hit(x_prog_hit), .offset(x_prog_off));
	cmm_region #(.W(ADDR_W), .BASE(AUX_BASE), .SIZE(AUX_LIMIT))
		u_x_aux (.addr(xdata_addr), .hit(x_aux_hit), .offset(x_aux_off));

	// Internal data and special function areas, 8-bit space
	cmm_region #(.W(IADDR_W), .BASE(IDATA_BASE), .SIZE(IDATA_SIZE))
		u_i_ram (.addr(idata_addr), .hit(i_ram_hit), .offset(i_ram_off));
	cmm_region #(.W(IADDR_W), .BASE(SFR_BASE), .SIZE(SFR_SIZE))
		u_i_sfr (.addr(idata_addr), .hit(i_sfr_hit), .offset(i_sfr_off));

	// Which memories each mode opens in code and data space
	assign map_code_prog = (chip_mode == CMM_NORMAL); // RL8
	assign map_code_boot = (chip_mode == CMM_BOOT) // RL9
		|| (chip_mode == CMM_BOOT_AUX); // RL12
	assign map_code_aux  = (chip_mode == CMM_NORMAL_AUX) // RL11
		|| (chip_mode == CMM_BOOT_AUX); // RL12
	assign map_data_aux  = (chip_mode == CMM_NORMAL) // RL8
		|| (chip_mode == CMM_BOOT); // RL10
	assign map_data_prog = (chip_mode != CMM_NORMAL); // RL10 RL11 RL12

	// Code fetch routing; regions in one mode never overlap
	assign next_f_prog = fetch_req && map_code_prog && f_prog_hit; // RL13
	assign next_f_boot = fetch_req && map_code_boot && f_boot_hit; // RL13
	assign next_f_aux  = fetch_req && map_code_aux && f_aux_hit;
	assign next_f_off  = next_f_aux ? f_aux_off
		: next_f_boot ? f_boot_off
		: next_f_prog ? f_prog_off : 16'h0000;

	// Data routing; program memory writable where mapped as data
	assign next_x_prog = xdata_req && map_data_prog && x_prog_hit;
	assign next_x_aux  = xdata_req && map_data_aux && x_aux_hit; // RL14
	assign next_x_off  = next_x_aux ? x_aux_off
		: next_x_prog ? x_prog_off : 16'h0000;

	// Direct upper half goes to the function area, all else to RAM
	assign next_i_sfr = idata_req && idata_direct && i_sfr_hit; // RL15
	assign next_i_ram = idata_req && !next_i_sfr && i_ram_hit; // RL14
	assign next_i_off = next_i_sfr ? i_sfr_off
		: next_i_ram ? i_ram_off : 8'h00;

	// Registered code select, one cycle after the request
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			fetch_prog_sel <= 1'b0;
			fetch_boot_sel <= 1'b0;
			fetch_aux_sel  <= 1'b0;
			fetch_miss     <= 1'b0;
			fetch_offset   <= 16'h0000;
		end
		else
		begin
			fetch_prog_sel <= next_f_prog;
			fetch_boot_sel <= next_f_boot;
			fetch_aux_sel  <= next_f_aux;
			fetch_miss     <= fetch_req
				&& !(next_f_prog || next_f_boot || next_f_aux);
			fetch_offset   <= next_f_off;
		end
	end

	// Registered data selects; a miss flags an unmapped access
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			xdata_prog_sel <= 1'b0;
			xdata_aux_sel  <= 1'b0;
			xdata_miss     <= 1'b0;
			xdata_offset   <= 16'h0000;
			idata_ram_sel  <= 1'b0;
			sfr_sel        <= 1'b0;
			idata_offset   <= 8'h00;
		end
		else
		begin
			xdata_prog_sel <= next_x_prog;
			xdata_aux_sel  <= next_x_aux;
			xdata_miss     <= xdata_req && !(next_x_prog || next_x_aux);
			xdata_offset   <= next_x_off;
			idata_ram_sel  <= next_i_ram;
			sfr_sel        <= next_i_sfr;
			idata_offset   <= next_i_off;
		end
	end

endmodule

// file: tb/cmm_chip_mode_sva.sv
// Concurrent checks on the chip mode and memory map ports
`timescale 1ns/1ps
module cmm_chip_mode_sva
	import cmm_pkg::*;
(
	input wire logic          core_clk,
	input wire logic          rst_b,
	input wire logic          boot_select_pin,
	input wire logic          ctl_wr,
	input wire logic          boot_loader_enable_bit,
	input wire logic          code_swap_bit,
	input wire logic          unlock_wr,
	input wire logic [7:0]    unlock_data,
	input wire logic          fetch_req,
	input wire logic [15:0]   fetch_addr,
	input wire logic          xdata_req,
	input wire logic [15:0]   xdata_addr,
	input wire logic          idata_req,
	input wire logic          idata_direct,
	input wire logic [7:0]    idata_addr,
	input cmm_pkg::cmm_mode_t chip_mode,
	input wire logic          mode_loaded,
	input wire logic          unlock_armed,
	input wire logic          unlock_abort,
	input wire logic          fetch_prog_sel,
	input wire logic          fetch_boot_sel,
	input wire logic [15:0]   fetch_offset,
	input wire logic          xdata_aux_sel,
	input wire logic          idata_ram_sel,
	input wire logic          sfr_sel
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	// Control write then both keys on back to back cycles
	sequence unlock_seq;
		ctl_wr ##1 (unlock_wr && !ctl_wr && unlock_data == UNLOCK_KEY1)
		##1 (unlock_wr && !ctl_wr && unlock_data == UNLOCK_KEY2);
	endsequence

	strap_load_a: assert property ($rose(rst_b) |=>
		chip_mode == (boot_select_pin ? CMM_NORMAL : CMM_BOOT)
		&& mode_loaded)
		else $error("strap mode not loaded");
	// Enum order matches the bit pairs, swap bit high, enable bit low
	unlock_mode_a: assert property (unlock_seq |=>
		chip_mode == cmm_mode_t'({$past(code_swap_bit, 3),
		$past(boot_loader_enable_bit, 3)}) && mode_loaded)
		else $error("unlock did not load mode");
	mode_hold_a: assert property ($changed(chip_mode) |->
		$past(unlock_wr) || !$past(rst_b, 2))
		else $error("mode changed without unlock");
	armed_bound_a: assert property ($rose(unlock_armed) |->
		##[1:18] !unlock_armed)
		else $error("sequence never timed out");
	bad_key_a: assert property (unlock_armed && unlock_wr && !ctl_wr
		&& unlock_data != UNLOCK_KEY1 && unlock_data != UNLOCK_KEY2
		|=> unlock_abort && $stable(chip_mode))
		else $error("wrong key not refused");
	normal_fetch_a: assert property (fetch_req && chip_mode == CMM_NORMAL
		&& fetch_addr < 16'h2000 |=> fetch_prog_sel
		&& fetch_offset == $past(fetch_addr))
		else $error("normal fetch misrouted");
	boot_fetch_a: assert property (fetch_req && chip_mode[0]
		&& fetch_addr < 16'h1000 |=> fetch_boot_sel && !fetch_prog_sel)
		else $error("boot fetch misrouted");
	data_aux_a: assert property (xdata_req && xdata_addr >= 16'hFF00
		|=> xdata_aux_sel == !$past(chip_mode[1]))
		else $error("aux data select wrong");
	sfr_split_a: assert property (idata_req |=>
		sfr_sel == ($past(idata_direct) && $past(idata_addr[7]))
		&& idata_ram_sel == !sfr_sel)
		else $error("internal space split wrong");
endmodule

// file: tb/testbench.sv
// Self-checking bench for the chip mode and memory map block
`timescale 1ns/1ps
module testbench;
	import cmm_pkg::*;
	logic        core_clk, rst_b, boot_select_pin, ctl_wr, unlock_wr;
	logic        boot_loader_enable_bit, code_swap_bit, fetch_req, xdata_req;
	logic        idata_req, idata_direct, mode_loaded, unlock_armed;
	logic        unlock_abort, fetch_prog_sel, fetch_boot_sel, fetch_aux_sel;
	logic        fetch_miss, xdata_prog_sel, xdata_aux_sel, xdata_miss;
	logic        idata_ram_sel, sfr_sel;
	logic [7:0]  unlock_data, idata_addr, idata_offset;
	logic [15:0] fetch_addr, xdata_addr, fetch_offset, xdata_offset;
	cmm_mode_t   chip_mode, exp_mode;
	int          error_cnt, num_checks, cyc;
	logic [15:0] tab [7];

	cmm_chip_mode dut_u
	(
		.core_clk               (core_clk),
		.rst_b                  (rst_b),
		.boot_select_pin        (boot_select_pin),
		.ctl_wr                 (ctl_wr),
		.boot_loader_enable_bit (boot_loader_enable_bit),
		.code_swap_bit          (code_swap_bit),
		.unlock_wr              (unlock_wr),
		.unlock_data            (unlock_data),
		.fetch_req              (fetch_req),
		.fetch_addr             (fetch_addr),
		.xdata_req              (xdata_req),
		.xdata_addr             (xdata_addr),
		.idata_req              (idata_req),
		.idata_direct           (idata_direct),
		.idata_addr             (idata_addr),
		.chip_mode              (chip_mode),
		.mode_loaded            (mode_loaded),
		.unlock_armed           (unlock_armed),
		.unlock_abort           (unlock_abort),
		.fetch_prog_sel         (fetch_prog_sel),
		.fetch_boot_sel         (fetch_boot_sel),
		.fetch_aux_sel          (fetch_aux_sel),
		.fetch_miss             (fetch_miss),
		.fetch_offset           (fetch_offset),
		.xdata_prog_sel         (xdata_prog_sel),
		.xdata_aux_sel          (xdata_aux_sel),
		.xdata_miss             (xdata_miss),
		.xdata_offset           (xdata_offset),
		.idata_ram_sel          (idata_ram_sel),
		.sfr_sel                (sfr_sel),
		.idata_offset           (idata_offset)
	);

	// Free running 25 MHz clock
	always #20 core_clk = ~core_clk;

	task automatic chk(input string nm, input logic [15:0] got, exp);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic results();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Reset long enough for the pin synchroniser to settle
	task automatic do_reset(input logic pin);
		@(negedge core_clk);
		rst_b = 1'b0;
		boot_select_pin = pin;
		repeat (10) @(negedge core_clk);
		chk("chip_mode", chip_mode, MODE_RESET);
		rst_b = 1'b1;
		exp_mode = pin ? CMM_NORMAL : CMM_BOOT;
		@(negedge core_clk);
		chk("chip_mode", chip_mode, exp_mode);
		chk("mode_loaded", mode_loaded, 1'b1);
		@(negedge core_clk);
		chk("mode_loaded", mode_loaded, 1'b0);
	endtask

	// Pin set against the request, since software ignores it
	task automatic sw_mode(input logic en, sw, input logic [7:0] k1, k2);
		@(negedge core_clk);
		ctl_wr = 1'b1;
		boot_loader_enable_bit = en;
		code_swap_bit = sw;
		boot_select_pin = en;
		@(negedge core_clk);
		ctl_wr = 1'b0;
		unlock_wr = 1'b1;
		unlock_data = k1;
		@(negedge core_clk);
		unlock_data = k2;
		@(negedge core_clk);
		unlock_wr = 1'b0;
	endtask

	// Fetch and data access to one address against the mode map
	task automatic dec(input logic [15:0] a);
		logic n, b, fp, fb, fa, xp, xa;
		n = exp_mode == CMM_NORMAL;
		b = exp_mode == CMM_BOOT;
		fp = n && a < 16'h2000;
		fb = (b || exp_mode == CMM_BOOT_AUX) && a < 16'h1000;
		fa = !n && !b && a >= 16'hFF00;
		xp = !n && a < 16'h2000;
		xa = (n || b) && a >= 16'hFF00;
		@(negedge core_clk);
		fetch_req = 1'b1;
		xdata_req = 1'b1;
		fetch_addr = a;
		xdata_addr = a;
		@(negedge core_clk);
		fetch_req = 1'b0;
		xdata_req = 1'b0;
		chk("fetch_prog_sel", fetch_prog_sel, fp);
		chk("fetch_boot_sel", fetch_boot_sel, fb);
		chk("fetch_aux_sel", fetch_aux_sel, fa);
		chk("fetch_miss", fetch_miss, !(fp || fb || fa));
		chk("fetch_offset", fetch_offset, fa ? {8'h00, a[7:0]}
			: (fp || fb ? a : 16'h0000));
		chk("xdata_prog_sel", xdata_prog_sel, xp);
		chk("xdata_aux_sel", xdata_aux_sel, xa);
		chk("xdata_miss", xdata_miss, !(xp || xa));
		chk("xdata_offset", xdata_offset, xa ? {8'h00, a[7:0]}
			: (xp ? a : 16'h0000));
	endtask

	// Every bit pair, then the whole boundary table in that mode
	task automatic t_soft();
		for (int i = 0; i < 4; i++)
		begin
			sw_mode(i[1], i[0], UNLOCK_KEY1, UNLOCK_KEY2);
			exp_mode = cmm_mode_t'({i[0], i[1]});
			chk("chip_mode", chip_mode, exp_mode);
			chk("mode_loaded", mode_loaded, 1'b1);
			@(negedge core_clk);
			chk("mode_loaded", mode_loaded, 1'b0);
			foreach (tab[j])
				dec(tab[j]);
		end
	endtask

	// Keys swapped, a wrong key, and a control write left to expire
	task automatic t_refuse();
		sw_mode(1'b0, 1'b0, UNLOCK_KEY2, UNLOCK_KEY1);
		chk("chip_mode", chip_mode, exp_mode);
		sw_mode(1'b0, 1'b0, 8'h00, UNLOCK_KEY2);
		chk("chip_mode", chip_mode, exp_mode);
		sw_mode(1'b1, 1'b0, UNLOCK_KEY1, 8'h5A);
		chk("chip_mode", chip_mode, exp_mode);
		@(negedge core_clk);
		ctl_wr = 1'b1;
		@(negedge core_clk);
		ctl_wr = 1'b0;
		repeat (UNLOCK_CYC) @(negedge core_clk);
		chk("unlock_armed", unlock_armed, 1'b1);
		chk("unlock_abort", unlock_abort, 1'b0);
		@(negedge core_clk);
		chk("unlock_armed", unlock_armed, 1'b0);
		chk("unlock_abort", unlock_abort, 1'b1);
		repeat (3) @(negedge core_clk);
		chk("chip_mode", chip_mode, exp_mode);
		chk("unlock_armed", unlock_armed, 1'b0);
	endtask

	// Direct upper half is the special function area
	task automatic idat(input logic dir, input logic [7:0] a);
		logic s;
		s = dir && a[7];
		@(negedge core_clk);
		idata_req = 1'b1;
		idata_direct = dir;
		idata_addr = a;
		@(negedge core_clk);
		idata_req = 1'b0;
		chk("sfr_sel", sfr_sel, s);
		chk("idata_ram_sel", idata_ram_sel, !s);
		chk("idata_offset", idata_offset, s ? a - 8'h80 : a);
	endtask

	initial
	begin
		{core_clk, rst_b, ctl_wr, unlock_wr, fetch_req, xdata_req} = '0;
		{boot_loader_enable_bit, code_swap_bit, idata_req} = '0;
		{boot_select_pin, idata_direct, unlock_data, idata_addr} = '0;
		{fetch_addr, xdata_addr, error_cnt, num_checks, cyc} = '0;
		tab = '{16'h0000, 16'h0FFF, 16'h1000, 16'h1FFF, 16'h2000,
			16'hFF00, 16'hFFFF};
		do_reset(1'b1);
		do_reset(1'b0);
		t_soft();
		t_refuse();
		idat(1'b1, 8'h7F);
		idat(1'b1, 8'h80);
		idat(1'b1, 8'hFF);
		idat(1'b0, 8'hC0);
		do_reset(1'b0);
		results();
	end

	// Ceiling far above the roughly 160 cycles the run needs
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			error_cnt++;
			results();
		end
	end
endmodule

bind cmm_chip_mode cmm_chip_mode_sva chk_u
(
	.core_clk               (core_clk),
	.rst_b                  (rst_b),
	.boot_select_pin        (boot_select_pin),
	.ctl_wr                 (ctl_wr),
	.boot_loader_enable_bit (boot_loader_enable_bit),
	.code_swap_bit          (code_swap_bit),
	.unlock_wr              (unlock_wr),
	.unlock_data            (unlock_data),
	.fetch_req              (fetch_req),
	.fetch_addr             (fetch_addr),
	.xdata_req              (xdata_req),
	.xdata_addr             (xdata_addr),
	.idata_req              (idata_req),
	.idata_direct           (idata_direct),
	.idata_addr             (idata_addr),
	.chip_mode              (chip_mode),
	.mode_loaded            (mode_loaded),
	.unlock_armed           (unlock_armed),
	.unlock_abort           (unlock_abort),
	.fetch_prog_sel         (fetch_prog_sel),
	.fetch_boot_sel         (fetch_boot_sel),
	.fetch_offset           (fetch_offset),
	.xdata_aux_sel          (xdata_aux_sel),
	.idata_ram_sel          (idata_ram_sel),
	.sfr_sel                (sfr_sel)
);
